//--- shared/bss_pkg.sv
// Constants shared by the buck start-up and fault sequencer
package bss_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_PERIOD = 12'h008;
    localparam int          CTRL_RUN_BIT  = 0;
    localparam logic        CTRL_RUN_RST  = 1'b1;
    localparam logic [15:0] PERIOD_RST    = 16'h01a1;
    localparam int          ST_POR_BIT    = 0;
    localparam int          ST_STATE_LSB  = 1;
    localparam int          ST_OC_BIT     = 6;
    localparam int          ST_BIAS_BIT   = 7;
    localparam int          ST_PB_BIT     = 8;
    localparam int          ST_HOT_BIT    = 9;
    localparam int          ST_SS_LSB     = 16;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PS          = 4000;
    localparam int T_HICCUP_US     = 20480;
    localparam int HICCUP_CYC      = T_HICCUP_US / (CLK_PS / 1000) * 1000;
    localparam int T_SS_TICK_NS    = 1000;
    localparam int SS_TICK_CYC     = (T_SS_TICK_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int T_SAMP_WIN_PS   = 30000;
    localparam int SAMP_WIN_CYC    = T_SAMP_WIN_PS / CLK_PS;
    localparam int T_SAMP_DLY_PS   = 40000;
    localparam int SAMP_DLY_CYC    = (T_SAMP_DLY_PS + CLK_PS - 1) / CLK_PS;
    // Soft-start reference in 0.1 mV units: 0.4 mV per microsecond up to 1.5 V
    localparam logic [13:0] SS_INC = 14'h0004;
    localparam logic [13:0] SS_MAX = 14'h3a98;
    localparam logic [3:0]  PB_LAST_PULSE = 4'hf;
    localparam logic [3:0]  PB_LAST_STEP  = 4'h8;
    localparam logic [8:0]  ZC_LAST       = 9'h0ff;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_OFF    = 5'b00001,
        ST_SOFT   = 5'b00010,
        ST_RUN    = 5'b00100,
        ST_HICCUP = 5'b01000,
        ST_THERM  = 5'b10000
    } bss_state_e;
endpackage : bss_pkg

//--- hw/bss_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module bss_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] agree;

    assign agree = ~(s2 ^ s3);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= (agree & s3) | (~agree & q);
        end
    end
endmodule : bss_sync

//--- hw/bss_sequencer.sv
// Start-up, pre-bias, hiccup, thermal and gate-drive bias sequencer
// Function
// - Both gates off while bias or enable comparator is low; resume when both high.
// - Ready only with all inputs valid; ready launches soft-start.
// - Turn on only after enable comparator reports above the 1.2V threshold.
// - Enable below 1.0V turns both drivers off.
// - Low-side stays off until the first high-side pulse.
// - Low-side limit starts at one eighth of period, rising by eighths.
// - Each pre-bias step lasts 16 pulses, eight steps in all.
// - Soft-start reference ramps 0 to 1.5V at 0.4mV per microsecond.
// - Over-current and over-voltage guards stay active during soft-start.
// - Current limit select pin decodes three states into three limits.
// - Sample low-side current 30ns, one eighth period before the valley; window is 7 cycles, 28ns.
// - Short low-side on-time: sample 40ns after the falling slope starts.
// - Sampled current above the selected limit flags over-current.
// - Over-current latches fault and holds reference at zero for 20.48ms.
// - After hiccup, clear fault and redo soft-start; repeat while overloaded.
// - Thermal trip turns both switches off and resets the reference.
// - Restart once temperature falls below the release point.
// - Low gate-drive bias at light load, high bias otherwise.
// - Low bias only after 256 consecutive zero-crossing cycles.
// - A cycle without zero crossing clears the count, bias goes high.
`timescale 1ns/10ps
module bss_sequencer
    import bss_pkg::*;
#(
    parameter int HICCUP_CYCLES = HICCUP_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        undervoltage_lockout_ok,
    input  wire logic        enable_above_on,
    input  wire logic        enable_below_off,
    input  wire logic        thermal_trip,
    input  wire logic        thermal_release,
    input  wire logic        current_limit_select_vcc,
    input  wire logic        current_limit_select_gnd,
    input  wire logic [2:0]  current_over_limit,
    input  wire logic        zero_cross_det,
    input  wire logic        overvoltage_guard,
    input  wire logic        pwm_high_req,
    output logic             high_side_switch,
    output logic             low_side_switch,
    output logic             por_ready,
    output logic      [13:0] ss_ref,
    output logic             gate_drive_low,
    output logic             overcurrent_fault
);
    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    logic [12:0] pin_s;
    bss_sync #(.W(13)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({pwm_high_req, overvoltage_guard, zero_cross_det, current_over_limit,
                   current_limit_select_gnd, current_limit_select_vcc, thermal_release,
                   thermal_trip, enable_below_off, enable_above_on, undervoltage_lockout_ok}),
        .q       (pin_s)
    );

    wire       bias_ok_s = pin_s[0];
    wire       en_on_s   = pin_s[1];
    wire       en_off_s  = pin_s[2];
    wire       hot_s     = pin_s[3];
    wire       cool_s    = pin_s[4];
    wire       sel_vcc_s = pin_s[5];
    wire       sel_gnd_s = pin_s[6];
    wire [2:0] over_s    = pin_s[9:7];
    wire       zc_s      = pin_s[10];
    wire       ov_s      = pin_s[11];
    wire       hs_req_s  = pin_s[12];

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    bss_state_e  state;
    bss_state_e  next_state;
    logic        ctrl_run;
    logic [15:0] period;
    logic        enabled;
    logic        hot;
    logic [15:0] per_cnt;
    logic [7:0]  tick_cnt;
    logic [22:0] hic_cnt;
    logic        first_hs;
    logic        pb_active;
    logic [3:0]  pb_step;
    logic [3:0]  pb_pulse;
    logic [15:0] ls_cnt;
    logic [15:0] ls_begin;
    logic        zc_seen;
    logic [8:0]  zc_cnt;

    // ----------------------------------------------------------------
    // Enable and thermal hysteresis
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enabled <= 1'b0;
            hot     <= 1'b0;
        end else begin
            enabled <= en_on_s | (enabled & ~en_off_s);
            hot     <= hot_s | (hot & ~cool_s);
        end
    end

    // Software run bit acts as a second enable
    wire por_ok = bias_ok_s & enabled & ctrl_run & ~hot;

    // ----------------------------------------------------------------
    // Switching period and current sample window
    // ----------------------------------------------------------------
    wire        per_start = (per_cnt == 16'h0000);
    wire [15:0] eighth    = {3'b000, period[15:3]};
    wire [15:0] win_pt    = period - eighth;
    wire [15:0] win_end   = win_pt + 16'(SAMP_WIN_CYC);
    wire        ls_short  = (ls_begin > win_pt);
    wire        win_norm  = (per_cnt >= win_pt) & (per_cnt < win_end);
    wire        win_short = (ls_cnt >= 16'(SAMP_DLY_CYC))
                          & (ls_cnt < 16'(SAMP_DLY_CYC + SAMP_WIN_CYC));
    wire        sampling  = low_side_switch & (ls_short ? win_short : win_norm);
    wire [1:0]  lim_sel   = sel_vcc_s ? 2'd2 : (sel_gnd_s ? 2'd0 : 2'd1);
    wire        oc_event  = sampling & over_s[lim_sel];
    wire        running   = (state == ST_SOFT) | (state == ST_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt <= 16'h0000;
        end else begin
            per_cnt <= (per_cnt >= period - 16'h0001) ? 16'h0000 : per_cnt + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer state machine
    // ----------------------------------------------------------------
    wire hic_done = (hic_cnt == 23'(HICCUP_CYCLES - 1));
    wire ss_top   = (ss_ref == SS_MAX);

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF:    if (por_ok) next_state = ST_SOFT;
            ST_SOFT: begin
                if (oc_event) next_state = ST_HICCUP;
                else if (ss_top) next_state = ST_RUN;
            end
            ST_RUN:    if (oc_event) next_state = ST_HICCUP;
            ST_HICCUP: if (hic_done) next_state = ST_SOFT;
            // Straight into soft-start, so ready and the ramp always start together
            ST_THERM:  if (!hot) next_state = por_ok ? ST_SOFT : ST_OFF;
            default:   next_state = ST_OFF;
        endcase
        if (hot) next_state = ST_THERM;
        else if (!por_ok && state != ST_THERM) next_state = ST_OFF;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state             <= ST_OFF;
            por_ready         <= 1'b0;
            overcurrent_fault <= 1'b0;
        end else begin
            state             <= next_state;
            por_ready         <= por_ok;
            overcurrent_fault <= (next_state == ST_HICCUP);
        end
    end

    // ----------------------------------------------------------------
    // Soft-start reference and hiccup timer
    // ----------------------------------------------------------------
    wire ss_tick = (tick_cnt == 8'(SS_TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 8'h00;
            ss_ref   <= 14'h0000;
            hic_cnt  <= 23'h000000;
        end else begin
            tick_cnt <= (ss_tick || next_state != ST_SOFT) ? 8'h00 : tick_cnt + 8'h01;
            if (next_state != ST_SOFT && next_state != ST_RUN) begin
                ss_ref <= 14'h0000;
            end else if (state == ST_SOFT && ss_tick && !ss_top) begin
                ss_ref <= ss_ref + SS_INC;
            end
            hic_cnt <= (state == ST_HICCUP) ? hic_cnt + 23'h000001 : 23'h000000;
        end
    end

    // ----------------------------------------------------------------
    // Gate drive with pre-bias low-side stepping
    // ----------------------------------------------------------------
    // Limit is step eighths of the period; step counts from one
    // Room is judged on next cycle's count, so a stretch lasts at most the limit
    wire [15:0] next_ls_cnt = low_side_switch ? ls_cnt + 16'h0001 : 16'h0000;
    wire [19:0] ls_limit    = eighth * pb_step;
    wire        ls_room     = !pb_active | ({4'h0, next_ls_cnt} < ls_limit);
    // Gates drop in the very cycle a state change is decided, never one late
    wire        gate_ok  = running & (next_state == state) & por_ok;
    wire        next_hs  = gate_ok & hs_req_s & ~ov_s;
    wire        next_ls  = gate_ok & ~hs_req_s & ~high_side_switch & first_hs & ls_room;
    wire        pb_wrap  = per_start & first_hs & pb_active & (pb_pulse == PB_LAST_PULSE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_side_switch <= 1'b0;
            low_side_switch  <= 1'b0;
            first_hs         <= 1'b0;
            pb_active        <= 1'b1;
            pb_step          <= 4'h1;
            pb_pulse         <= 4'h0;
            ls_cnt           <= 16'h0000;
            ls_begin         <= 16'h0000;
        end else begin
            high_side_switch <= next_hs;
            low_side_switch  <= next_ls;
            ls_cnt           <= next_ls_cnt;
            if (next_ls && !low_side_switch) ls_begin <= per_cnt;
            if (!running) begin
                first_hs  <= 1'b0;
                pb_active <= 1'b1;
                pb_step   <= 4'h1;
                pb_pulse  <= 4'h0;
            end else begin
                if (high_side_switch) first_hs <= 1'b1;
                if (per_start && first_hs && pb_active) pb_pulse <= pb_pulse + 4'h1;
                if (pb_wrap && pb_step == PB_LAST_STEP) pb_active <= 1'b0;
                else if (pb_wrap) pb_step <= pb_step + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Gate-drive bias selection
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zc_seen        <= 1'b0;
            zc_cnt         <= 9'h000;
            gate_drive_low <= 1'b0;
        end else if (!running) begin
            zc_seen        <= 1'b0;
            zc_cnt         <= 9'h000;
            gate_drive_low <= 1'b0;
        end else if (per_start) begin
            zc_seen <= zc_s;
            if (!zc_seen) begin
                zc_cnt         <= 9'h000;
                gate_drive_low <= 1'b0;
            end else if (zc_cnt == ZC_LAST) begin
                gate_drive_low <= 1'b1;
            end else begin
                zc_cnt <= zc_cnt + 9'h001;
            end
        end else if (zc_s) begin
            zc_seen <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait state so that read data comes from a flop
    wire        acc     = psel & penable & ~pready;
    wire        hit_ctl = (paddr == OFS_CTRL);
    wire        hit_st  = (paddr == OFS_STATUS);
    wire        hit_per = (paddr == OFS_PERIOD);
    wire        mapped  = hit_ctl | hit_st | hit_per;
    wire        wr_done = psel & penable & pready & pwrite & ~pslverr;
    wire [31:0] st_word = {2'b00, ss_ref, 6'h00, hot, pb_active, gate_drive_low,
                           overcurrent_fault, state, por_ready};
    wire [31:0] rd_mux  = hit_ctl ? {31'h0, ctrl_run} :
                          hit_st  ? st_word :
                          hit_per ? {16'h0000, period} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0;
            ctrl_run <= CTRL_RUN_RST;
            period   <= PERIOD_RST;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~mapped;
            prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0;
            if (wr_done && hit_ctl) ctrl_run <= pwdata[CTRL_RUN_BIT];
            if (wr_done && hit_per && pwdata[15:4] != 12'h000) period <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lockout_gates: assert property (!por_ok |=> !high_side_switch && !low_side_switch)
        else $error("gate driven while locked out");
    a_por_launch: assert property ($rose(por_ready) |-> state == ST_SOFT && ss_ref == 14'h0000)
        else $error("ready did not launch soft-start");
    a_ls_after_hs: assert property (low_side_switch |-> $past(first_hs))
        else $error("low-side before first high-side pulse");
    a_ls_limit: assert property (pb_active && low_side_switch |-> {4'h0, ls_cnt} < ls_limit)
        else $error("low-side exceeded pre-bias limit");
    a_step_hold: assert property ($changed(pb_step) && pb_step != 4'h1 |-> $past(pb_pulse) == PB_LAST_PULSE)
        else $error("pre-bias step changed early");
    a_ss_slope: assert property (state == ST_SOFT && $changed(ss_ref) && ss_ref != 14'h0000
                                 |-> ss_ref - $past(ss_ref) == SS_INC && ss_ref <= SS_MAX)
        else $error("soft-start slope wrong");
    a_oc_hiccup: assert property (oc_event && running && !hot && por_ok
                                  |=> state == ST_HICCUP ##1 ss_ref == 14'h0000 && overcurrent_fault)
        else $error("over-current did not start hiccup");
    a_hiccup_len: assert property (state == ST_HICCUP && hic_done && !hot && por_ok |=> state == ST_SOFT)
        else $error("hiccup did not restart soft-start");
    a_thermal_off: assert property (hot |=> state == ST_THERM ##1 !high_side_switch && ss_ref == 14'h0000)
        else $error("thermal trip did not shut down");
    a_bias_high: assert property (running && per_start && !zc_seen |=> !gate_drive_low)
        else $error("bias not returned high");
    a_ov_blocks_hs: assert property (ov_s |=> !high_side_switch)
        else $error("high side on during over-voltage");
    a_enable_off: assert property (en_off_s && !en_on_s |-> ##2 !por_ready)
        else $error("ready kept after enable fell");
    a_bias_low_count: assert property ($rose(gate_drive_low) |-> zc_cnt == ZC_LAST)
        else $error("low bias before full zero-crossing run");

    // Main scenarios the bench should reach

    c_hiccup: cover property (state == ST_SOFT ##1 state == ST_HICCUP);
    c_run: cover property (state == ST_SOFT ##1 state == ST_RUN);
    c_bias_low: cover property ($rose(gate_drive_low));
    c_pb_done: cover property ($fell(pb_active) && running);
    c_therm_restart: cover property (state == ST_THERM ##1 state == ST_SOFT);
endmodule : bss_sequencer

//--- verification/bss_bridge_model.sv
// Behavioural half-bridge and inductor feeding the sequencer's comparators
`timescale 1ns/10ps
module bss_bridge_model (
    input  wire logic        pclk,
    input  wire logic [15:0] period,
    input  wire logic        period_start,
    input  wire logic [2:0]  overload,
    input  wire logic        light_load,
    input  wire logic        low_side_switch,
    output logic             pwm_high_req,
    output logic      [2:0]  current_over_limit,
    output logic             zero_cross_det
);
    logic [15:0] cnt;
    // Ramp shares the sequencer's oscillator, so it realigns on each period start
    always_ff @(posedge pclk) begin
        if (period_start) cnt <= 16'h0001;
        else cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
    end
    // Short high-side request leaves a long low-side stretch for the valley sample
    assign pwm_high_req       = (cnt < {3'b000, period[15:3]});
    // Current is only seen through a conducting low side
    assign current_over_limit = low_side_switch ? overload : 3'b000;
    assign zero_cross_det     = light_load;
endmodule : bss_bridge_model

//--- verification/tb.sv
// Self-checking bench for the buck start-up and fault sequencer
`timescale 1ns/10ps
module tb;
    import bss_pkg::*;
    localparam int HC = 200;
    localparam int P  = 64;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        uv_ok, en_on, en_off, t_trip, t_rel, sel_vcc, sel_gnd, ovg, light;
    logic        pwm, zcd, hs, ls, por, gdl, ocf;
    logic [2:0]  ovl, col;
    logic [13:0] ss, s0;
    logic [15:0] per, rnd;
    logic [64:0] expq[$];
    logic [64:0] q;
    logic        hs_seen  = 1'b0;
    logic        ls_early = 1'b0;
    int          mismatches = 0;
    int          n_tests = 0;
    int          n, i;
    // Select pins, over-limit bits, fault expected
    logic [5:0]  cases[6] = '{6'b000010, 6'b010011, 6'b000101, 6'b100100, 6'b101001, 6'b110110};

    bss_sequencer #(.HICCUP_CYCLES(HC)) bss_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .undervoltage_lockout_ok(uv_ok), .enable_above_on(en_on), .enable_below_off(en_off),
        .thermal_trip(t_trip), .thermal_release(t_rel), .current_limit_select_vcc(sel_vcc),
        .current_limit_select_gnd(sel_gnd), .current_over_limit(col), .zero_cross_det(zcd),
        .overvoltage_guard(ovg), .pwm_high_req(pwm), .high_side_switch(hs), .low_side_switch(ls),
        .por_ready(por), .ss_ref(ss), .gate_drive_low(gdl), .overcurrent_fault(ocf));
    // Bridge ramp and sequencer period come from one oscillator in the real part
    bss_bridge_model bss_bridge_model_inst (.pclk(pclk), .period(per), .overload(ovl), .light_load(light),
        .period_start(bss_sequencer_inst.per_start),
        .low_side_switch(ls), .pwm_high_req(pwm), .current_over_limit(col), .zero_cross_det(zcd));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg = "value");
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("compared %0d, mismatched %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic fail(input string msg);
        mismatches++;
        $display("MISMATCH t=%0t timeout %s", $time, msg);
        test_done();
    endtask : fail

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m, input logic err);
        int k;
        expq.push_back({err, m, e});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) fail("apb");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic cond(input int c);
        case (c)
            0: return por === 1'b1;
            1: return por === 1'b0;
            2: return ocf === 1'b1;
            3: return ocf === 1'b0;
            4: return gdl === 1'b1;
            5: return gdl === 1'b0;
            6: return hs === 1'b1;
            default: return ss !== s0;
        endcase
    endfunction : cond

    // Bounded wait; n returns the cycles spent
    task automatic wait_for(input int c, input int lim, input logic must);
        n = 0;
        while (!cond(c) && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (must && n >= lim) fail("wait");
    endtask : wait_for

    task automatic count_on(input int cyc, input logic both);
        int k;
        n = 0;
        for (k = 0; k < cyc; k++) begin
            @(posedge pclk);
            if (hs !== 1'b0 || (both && ls !== 1'b0)) n++;
        end
    endtask : count_on

    // Answer watcher: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            q = expq.pop_front();
            check({31'h0, pslverr}, {31'h0, q[64]}, "error flag");
            check(prdata & q[63:32], q[31:0] & q[63:32], "read data");
        end
        if (hs === 1'b1) hs_seen <= 1'b1;
        if (hs_seen !== 1'b1 && ls === 1'b1) ls_early <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {uv_ok, en_on, en_off, t_trip, t_rel, sel_vcc, sel_gnd, ovg, light} = 9'b001010000;
        ovl = 3'b000;
        per = 16'(P);
        presetn = 1'b0;
        void'($urandom(89));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_CTRL, 0, 32'h1, '1, 0);
        apb(0, OFS_PERIOD, 0, 32'h1a1, '1, 0);
        apb(0, OFS_STATUS, 0, 32'h2, 32'h2ff, 0);
        apb(0, 12'h00c, 0, 0, '1, 1);
        apb(1, 12'h00c, 32'h5, 0, '1, 1);
        apb(1, OFS_PERIOD, 32'h5, 0, '1, 0);
        apb(0, OFS_PERIOD, 0, 32'h1a1, '1, 0);
        rnd = 16'h0010 + 16'($urandom % 1000);
        apb(1, OFS_PERIOD, {16'h0, rnd}, 0, '1, 0);
        apb(0, OFS_PERIOD, 0, {16'h0, rnd}, '1, 0);
        apb(1, OFS_PERIOD, P, 0, '1, 0);
        $display("test registers done");
        uv_ok <= 1'b1;
        repeat (20) @(posedge pclk);
        check(por, 0);
        {uv_ok, en_on, en_off} <= 3'b010;
        repeat (20) @(posedge pclk);
        check(por, 0);
        uv_ok <= 1'b1;
        wait_for(0, 10, 1);
        check(n >= 3, 1);
        apb(0, OFS_STATUS, 0, 32'h5, 32'h2ff, 0);
        wait_for(6, 4 * P, 1);
        check(ls_early, 0);
        s0 = ss;
        wait_for(7, 300, 1);
        s0 = ss;
        wait_for(7, 300, 1);
        check(n, 250);
        check(ss - s0, 4);
        ovg <= 1'b1;
        repeat (8) @(posedge pclk);
        count_on(3 * P, 0);
        check(n, 0);
        ovg <= 1'b0;
        light <= 1'b1;
        wait_for(4, 260 * P, 1);
        check(n >= 254 * P, 1);
        apb(0, OFS_STATUS, 0, 32'h80, 32'h80, 0);
        light <= 1'b0;
        wait_for(5, 3 * P, 1);
        {en_on, en_off} <= 2'b01;
        wait_for(1, 10, 1);
        count_on(3 * P, 1);
        check(n, 0);
        check(ss, 0);
        apb(0, OFS_STATUS, 0, 32'h2, 32'h2ff, 0);
        $display("test start and shutdown done");
        for (i = 0; i < 6; i++) begin
            {sel_vcc, sel_gnd} <= cases[i][5:4];
            {en_on, en_off} <= 2'b10;
            wait_for(0, 40, 1);
            ovl <= cases[i][3:1];
            wait_for(2, 130 * P, 0);
            check(ocf, cases[i][0]);
            if (cases[i][0]) begin
                repeat (2) @(posedge pclk);
                check(ss, 0);
                wait_for(3, HC + 20, 1);
                check(n >= HC - 6 && n <= HC + 4, 1);
                apb(0, OFS_STATUS, 0, 32'h5, 32'h7f, 0);
                wait_for(2, 130 * P, 1);
            end
            ovl <= 3'b000;
            {en_on, en_off} <= 2'b01;
            wait_for(1, 40, 1);
        end
        $display("test over-current done");
        {en_on, en_off} <= 2'b10;
        wait_for(0, 40, 1);
        {t_trip, t_rel} <= 2'b10;
        repeat (8) @(posedge pclk);
        count_on(2 * P, 1);
        check(n, 0);
        check(ss, 0);
        apb(0, OFS_STATUS, 0, 32'h220, 32'h27e, 0);
        t_trip <= 1'b0;
        repeat (20) @(posedge pclk);
        apb(0, OFS_STATUS, 0, 32'h220, 32'h27e, 0);
        t_rel <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(0, OFS_STATUS, 0, 32'h4, 32'h27e, 0);
        apb(1, OFS_CTRL, 32'h0, 0, '1, 0);
        wait_for(1, 10, 1);
        $display("test thermal done");
        test_done();
    end
endmodule : tb
